// ==== acpsc_top.sv ====
`timescale 1ns/1ps
// Operation
// R01 - select field picks divided oscillator or rc
// R02 - pin select bit one makes pin analog
// R03 - analog pin disables pull-up and change interrupt
// R04 - host waits acquisition time before starting
// R05 - only rc clock converts through sleep
// R06 - rc clock delays start one instruction
// R07 - completion clears go and loads result
// R08 - completion in sleep with interrupt wakes
// R09 - completion in sleep without interrupt powers down
// R10 - sleep on other clock aborts and powers down
// R11 - reset clears control, keeps result registers
// R12 - select register resets to all pins analog
// R13 - divider restarts when a conversion begins
module acpsc_top
   import acpsc_pkg::*;
(
   input wire logic I_REF_CLK,
   input wire logic I_SYS_RST,
   // ahb-lite slave
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic O_HRESP,
   // processor core
   input wire logic I_SLEEP,      // core is in sleep
   output logic O_WAKE,           // wake request pulse
   output logic O_CONV_DONE,      // conversion complete pulse
   // analog front end
   input wire logic I_CMP,        // comparator: input above trial level
   output logic [9:0] O_DAC_CODE, // trial level for the comparator
   output logic O_CONV_POWER,     // converter powered
   output logic O_HOLD,           // hold capacitor disconnected
   output logic [1:0] O_CHANNEL,  // selected input channel
   // pin control
   output logic [3:0] O_ANALOG_EN,
   output logic [3:0] O_PULLUP_DIS,
   output logic [3:0] O_IOC_DIS
);

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} acpsc_state_t;

   acpsc_state_t state_reg, state_next;
   acpsc_ctrl_t ctrl_reg;          // control register
   logic [7:0] sel_reg;            // analog select register
   logic [7:0] res_hi_reg;         // result_high, never reset
   logic [7:0] res_lo_reg;         // result_low, never reset
   acpsc_ahb_req_t req_reg;        // pending data phase
   logic pwr_down_reg;             // converter forced off by sleep
   logic [1:0] dly_cnt_reg;        // instruction-cycle delay count
   logic [9:0] sar_reg;            // successive approximation result
   logic [3:0] bit_reg;            // bit under trial
   logic hold_reg;                 // first tad of the conversion taken
   logic done_reg;                 // completion pulse
   logic wake_reg;                 // wake pulse
   logic [31:0] rdata_reg;         // read data

   logic addr_phase;               // transfer taken this cycle
   logic wr_ctrl, wr_sel;          // data phase writes
   logic [7:0] wdata;              // low byte of write data
   acpsc_ctrl_t wctrl;             // write data seen as control
   logic [2:0] clk_sel;            // conv_clock_select field
   logic [3:0] pin_sel;            // analog_pin_select field
   logic rc_sel;                   // rc clock selected
   logic tad_tick;                 // conversion clock enable
   logic start_req;                // software asks for a conversion
   logic abort_req;                // conversion must stop now
   logic sleep_off;                // sleep kills the converter
   logic conv_last;                // final bit decided this tick
   logic finish;                   // conversion completes this cycle
   logic [9:0] trial_bit;          // one-hot of bit under trial
   logic [9:0] sar_final;          // result including the last decision
   logic [7:0] fmt_hi, fmt_lo;     // justified result bytes
   logic [7:0] rd_byte;            // selected read byte

   // -----------------------------------------------------------------
   // ahb-lite decode
   // -----------------------------------------------------------------
   assign addr_phase = I_HSEL && I_HTRANS[1] && I_HREADY;
   assign wdata = I_HWDATA[7:0];
   assign wctrl = acpsc_ctrl_t'(wdata);
   assign wr_ctrl = req_reg.valid && req_reg.write
                    && (req_reg.addr == acpsc_word_addr(IDX_CTRL));
   assign wr_sel = req_reg.valid && req_reg.write
                   && (req_reg.addr == acpsc_word_addr(IDX_ANALOG_SEL));
   // the slave never stretches a transfer and never errors
   assign O_HREADYOUT = 1'b1;
   assign O_HRESP = 1'b0;
   assign O_HRDATA = rdata_reg;

   // read mux from the address phase; unmapped words read zero
   assign rd_byte =
      (I_HADDR[11:0] == acpsc_word_addr(IDX_CTRL)) ? 8'(ctrl_reg) :
      (I_HADDR[11:0] == acpsc_word_addr(IDX_ANALOG_SEL)) ? sel_reg :
      (I_HADDR[11:0] == acpsc_word_addr(IDX_RESULT_HIGH)) ? res_hi_reg :
      (I_HADDR[11:0] == acpsc_word_addr(IDX_RESULT_LOW)) ? res_lo_reg :
      8'h00;

   // capture the address phase and the read word
   always_ff @(posedge I_REF_CLK)
   begin
      if (I_SYS_RST)
      begin
         req_reg <= '0;
         rdata_reg <= 32'h0000_0000;
      end
      else if (I_HREADY)
      begin
         req_reg.valid <= addr_phase;
         req_reg.write <= I_HWRITE;
         req_reg.addr <= I_HADDR[11:0];
         // a read right behind a write to the same word sees old data
         rdata_reg <= (addr_phase && !I_HWRITE) ? {24'h00_0000, rd_byte}
                                                : 32'h0000_0000;
      end
   end

   // -----------------------------------------------------------------
   // analog select register and pin control
   // -----------------------------------------------------------------
   assign clk_sel = sel_reg[SEL_CS_LSB +: 3];
   assign pin_sel = sel_reg[SEL_PIN_LSB +: 4];
   assign rc_sel = acpsc_is_rc(clk_sel);

   // top bit is not stored, so it always reads zero
   always_ff @(posedge I_REF_CLK)
   begin
      if (I_SYS_RST)
         sel_reg <= ANALOG_SEL_RESET; // R12
      else if (wr_sel)
         sel_reg <= {1'b0, wdata[6:0]}; // R12
   end

   assign O_ANALOG_EN = pin_sel; // R02
   // digital input buffers stay quiet on analog pins
   assign O_PULLUP_DIS = pin_sel; // R03
   assign O_IOC_DIS = pin_sel; // R03

   // -----------------------------------------------------------------
   // conversion clock
   // -----------------------------------------------------------------
   acpsc_clkdiv acpsc_clkdiv_i (
      .i_clk(I_REF_CLK),
      .i_rst(I_SYS_RST),
      .i_restart(state_reg != ST_CONV), // R13
      .i_select(clk_sel),
      .o_tick(tad_tick)
   );

   // -----------------------------------------------------------------
   // start, abort and sleep decisions
   // -----------------------------------------------------------------
   // converter cannot run off the oscillator through sleep
   assign sleep_off = I_SLEEP && !rc_sel; // R05 R10
   assign start_req = wr_ctrl && wctrl.go_done && wctrl.converter_on
                      && !pwr_down_reg && !sleep_off
                      && (state_reg == ST_IDLE);
   // software clearing go or the enable also stops a conversion
   assign abort_req = sleep_off
                      || (wr_ctrl && !(wctrl.go_done && wctrl.converter_on));

   assign trial_bit = 10'h001 << bit_reg;
   assign conv_last = tad_tick && hold_reg && (bit_reg == 4'h0);
   assign finish = (state_reg == ST_CONV) && conv_last && !abort_req;
   assign sar_final = I_CMP ? (sar_reg | trial_bit) : sar_reg;

   // next state of the sequencer
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE:
            if (start_req)
               state_next = rc_sel ? ST_DELAY : ST_CONV; // R06
         ST_DELAY:
            if (abort_req)
               state_next = ST_IDLE;
            else if (dly_cnt_reg == 2'(INSTR_CLKS - 1))
               state_next = ST_CONV; // R06
         ST_CONV:
            if (abort_req || finish)
               state_next = ST_IDLE; // R10
      endcase
   end

   always_ff @(posedge I_REF_CLK)
   begin
      if (I_SYS_RST)
         state_reg <= ST_IDLE; // R11
      else
         state_reg <= state_next;
   end

   // instruction-cycle delay so a following sleep runs first
   always_ff @(posedge I_REF_CLK)
   begin
      if (I_SYS_RST || state_reg != ST_DELAY)
         dly_cnt_reg <= 2'h0;
      else
         dly_cnt_reg <= dly_cnt_reg + 2'h1; // R06
   end

   // -----------------------------------------------------------------
   // successive approximation
   // -----------------------------------------------------------------
   // first tad holds the sample; ten more decide one bit each
   always_ff @(posedge I_REF_CLK)
   begin
      if (I_SYS_RST || state_reg != ST_CONV)
      begin
         sar_reg <= 10'h000;
         bit_reg <= 4'(CONV_TADS - 2);
         hold_reg <= 1'b0;
      end
      else if (tad_tick)
      begin
         hold_reg <= 1'b1;
         if (hold_reg)
         begin
            sar_reg <= sar_final;
            bit_reg <= bit_reg - 4'h1;
         end
      end
   end

   assign O_DAC_CODE = (state_reg == ST_CONV && hold_reg)
                       ? (sar_reg | trial_bit) : 10'h000;
   assign O_HOLD = (state_reg == ST_CONV);

   // -----------------------------------------------------------------
   // result registers: no reset, they survive a device reset
   // -----------------------------------------------------------------
   assign fmt_hi = ctrl_reg.right_just ? {6'h00, sar_final[9:8]}
                                       : sar_final[9:2];
   assign fmt_lo = ctrl_reg.right_just ? sar_final[7:0]
                                       : {sar_final[1:0], 6'h00};

   always_ff @(posedge I_REF_CLK)
   begin
      if (finish)
      begin
         res_hi_reg <= fmt_hi; // R07 R11
         res_lo_reg <= fmt_lo; // R07
      end
   end

   // -----------------------------------------------------------------
   // control register
   // -----------------------------------------------------------------
   // go reads as busy; hardware clears it at the end or on abort
   always_ff @(posedge I_REF_CLK)
   begin
      if (I_SYS_RST)
         ctrl_reg <= acpsc_ctrl_t'(CTRL_RESET); // R11
      else
      begin
         if (wr_ctrl)
         begin
            ctrl_reg.right_just <= wctrl.right_just;
            ctrl_reg.irq_enable <= wctrl.irq_enable;
            ctrl_reg.channel <= wctrl.channel; // R04
            ctrl_reg.converter_on <= wctrl.converter_on;
         end
         ctrl_reg.unused <= 2'h0;
         // sleep never touches converter_on, only the power gate
         ctrl_reg.go_done <= (state_next != ST_IDLE); // R07 R10
      end
   end

   // -----------------------------------------------------------------
   // sleep power gate and wake
   // -----------------------------------------------------------------
   // forced off until the core leaves sleep
   always_ff @(posedge I_REF_CLK)
   begin
      if (I_SYS_RST || !I_SLEEP)
         pwr_down_reg <= 1'b0;
      else if (sleep_off)
         pwr_down_reg <= 1'b1; // R10
      else if (finish && !ctrl_reg.irq_enable)
         pwr_down_reg <= 1'b1; // R09
   end

   always_ff @(posedge I_REF_CLK)
   begin
      if (I_SYS_RST)
      begin
         done_reg <= 1'b0;
         wake_reg <= 1'b0;
      end
      else
      begin
         done_reg <= finish; // R07
         wake_reg <= finish && I_SLEEP && ctrl_reg.irq_enable; // R08
      end
   end

   assign O_CONV_DONE = done_reg;
   assign O_WAKE = wake_reg;
   assign O_CONV_POWER = ctrl_reg.converter_on && !pwr_down_reg; // R09 R10
   assign O_CHANNEL = ctrl_reg.channel;

endmodule // acpsc_top

// ==== acpsc_pkg.sv ====
package acpsc_pkg;

   // -----------------------------------------------------------------
   // clocking and timing
   // -----------------------------------------------------------------
   localparam int FOSC_KHZ = 25000;  // system clock rate
   localparam int RC_MAX_KHZ = 500;  // dedicated rc clock ceiling
   // round the divide up so the rc rate never passes its ceiling
   localparam int RC_DIV_CLKS = (FOSC_KHZ + RC_MAX_KHZ - 1) / RC_MAX_KHZ;
   localparam int INSTR_CLKS = 4;    // one instruction cycle = fosc / 4
   localparam int CONV_TADS = 11;    // one hold step plus ten bit trials

   // -----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // -----------------------------------------------------------------
   localparam logic [7:0] IDX_RESULT_HIGH = 8'h1e;
   localparam logic [7:0] IDX_CTRL = 8'h1f;
   localparam logic [7:0] IDX_RESULT_LOW = 8'h9e;
   localparam logic [7:0] IDX_ANALOG_SEL = 8'h9f;

   // -----------------------------------------------------------------
   // field positions and reset values
   // -----------------------------------------------------------------
   localparam int SEL_CS_LSB = 4;   // conv_clock_select in bits 6:4
   localparam int SEL_PIN_LSB = 0;  // analog_pin_select in bits 3:0
   localparam logic [7:0] ANALOG_SEL_RESET = 8'h0f;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // conversion clock select codes
   localparam logic [2:0] CS_DIV2 = 3'h0;
   localparam logic [2:0] CS_DIV8 = 3'h1;
   localparam logic [2:0] CS_DIV32 = 3'h2;
   localparam logic [2:0] CS_DIV4 = 3'h4;
   localparam logic [2:0] CS_DIV16 = 3'h5;
   localparam logic [2:0] CS_DIV64 = 3'h6;
   localparam logic [1:0] CS_RC_LOW = 2'h3;  // x11 picks the rc clock

   // control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic right_just;   // result format, 1 = right justified
      logic irq_enable;   // converter interrupt enable
      logic [1:0] unused; // reads zero
      logic [1:0] channel; // input channel select
      logic go_done;      // start / busy
      logic converter_on; // converter enable
   } acpsc_ctrl_t;

   // captured ahb address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic [11:0] addr;
   } acpsc_ahb_req_t;

   // byte address of a register index
   function automatic logic [11:0] acpsc_word_addr(input logic [7:0] idx);
      return {2'h0, idx, 2'h0};
   endfunction

   // true when the select field picks the dedicated rc clock
   function automatic logic acpsc_is_rc(input logic [2:0] cs);
      return (cs[1:0] == CS_RC_LOW);
   endfunction

endpackage

// ==== acpsc_clkdiv.sv ====
`timescale 1ns/1ps
module acpsc_clkdiv
   import acpsc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_restart,      // realigns the divider
   input wire logic [2:0] i_select, // conv_clock_select
   output logic o_tick              // one-cycle conversion clock enable
);

   // -----------------------------------------------------------------
   // divider state
   // -----------------------------------------------------------------
   logic [5:0] osc_cnt_reg; // oscillator divider, held at zero during i_restart
   logic [5:0] rc_cnt_reg;  // rc clock period counter
   logic [5:0] tap_mask;    // low bits that must all be one
   logic rc_sel;
   logic rc_wrap;
   logic tick_next;

   // pick the divider tap from the select code
   function automatic logic [5:0] tap_of(input logic [2:0] cs);
      unique case (cs)
         CS_DIV2: return 6'h01;
         CS_DIV4: return 6'h03;
         CS_DIV8: return 6'h07;
         CS_DIV16: return 6'h0f;
         CS_DIV32: return 6'h1f;
         CS_DIV64: return 6'h3f;
         default: return 6'h3f; // rc codes do not use the tap
      endcase
   endfunction

   assign rc_sel = acpsc_is_rc(i_select);
   assign tap_mask = tap_of(i_select); // R01
   assign rc_wrap = (rc_cnt_reg == 6'(RC_DIV_CLKS - 1));
   assign tick_next = rc_sel ? rc_wrap
                             : ((osc_cnt_reg & tap_mask) == tap_mask); // R01

   // -----------------------------------------------------------------
   // counters: restart at a conversion start so the first tad is whole
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_rst || i_restart)
      begin
         osc_cnt_reg <= 6'h00; // R13
         rc_cnt_reg <= 6'h00;
         o_tick <= 1'b0;
      end
      else
      begin
         osc_cnt_reg <= osc_cnt_reg + 6'h01; // R13
         rc_cnt_reg <= rc_wrap ? 6'h00 : rc_cnt_reg + 6'h01; // R01
         o_tick <= tick_next;
      end
   end

endmodule // acpsc_clkdiv

// ==== acpsc_top_sva.sv ====
`timescale 1ns/1ps
module acpsc_top_sva
   import acpsc_pkg::*;
(
   input wire logic I_REF_CLK,
   input wire logic I_SYS_RST,
   input wire logic I_SLEEP,
   input wire logic O_WAKE,
   input wire logic O_CONV_DONE,
   input wire logic [9:0] O_DAC_CODE,
   input wire logic O_CONV_POWER,
   input wire logic O_HOLD,
   input wire logic [3:0] O_ANALOG_EN,
   input wire logic [3:0] O_PULLUP_DIS,
   input wire logic [3:0] O_IOC_DIS
);
   // ------------------------------------------------------------
   // one clock domain, so one default clock and disable
   // ------------------------------------------------------------
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_SYS_RST);

   // analog pins lose pull-up and change interrupt together
   AST_PIN_MAP: assert property
      (O_PULLUP_DIS == O_ANALOG_EN && O_IOC_DIS == O_ANALOG_EN)
      else $error("pin disables differ from analog select");
   // first edge after reset shows all pins analog, converter off
   AST_RST_STATE: assert property
      ($fell(I_SYS_RST) |-> O_ANALOG_EN == 4'hf && !O_CONV_POWER && !O_HOLD)
      else $error("state after reset wrong");
   // completion is a single-cycle event
   AST_DONE_PULSE: assert property (O_CONV_DONE |=> !O_CONV_DONE)
      else $error("done pulse too long");
   // wake only comes with a completion while asleep
   AST_WAKE_WITH_DONE: assert property
      (O_WAKE |-> O_CONV_DONE && $past(I_SLEEP))
      else $error("wake without completion in sleep");
   // silent completion in sleep powers the converter down
   AST_SLEEP_DOWN: assert property
      (O_CONV_DONE && !O_WAKE && I_SLEEP && $past(I_SLEEP)
       |-> ##[0:2] !O_CONV_POWER)
      else $error("converter stayed powered after sleep completion");
   // no conversion runs on an unpowered converter
   AST_HOLD_POWER: assert property (O_HOLD |-> O_CONV_POWER)
      else $error("conversion while powered down");
   // completion ends the conversion state
   AST_DONE_ENDS_HOLD: assert property (O_CONV_DONE |-> !O_HOLD)
      else $error("still converting at completion");
   // completion only follows a running conversion
   AST_DONE_AFTER_HOLD: assert property
      (O_CONV_DONE |-> $past(O_HOLD, 1) || $past(O_HOLD, 2))
      else $error("completion without conversion");
   // trial level rests at zero outside a conversion
   AST_DAC_IDLE: assert property (!O_HOLD |-> O_DAC_CODE == 10'h0)
      else $error("trial code outside conversion");

   // main scenarios
   CV_WAKE: cover property (O_WAKE);
   CV_SILENT: cover property (O_CONV_DONE && !O_WAKE && I_SLEEP);
   CV_ABORT: cover property ($fell(O_HOLD) && I_SLEEP && !O_CONV_DONE);
endmodule // acpsc_top_sva

bind acpsc_top acpsc_top_sva acpsc_top_sva_i (.I_REF_CLK(I_REF_CLK),
   .I_SYS_RST(I_SYS_RST), .I_SLEEP(I_SLEEP), .O_WAKE(O_WAKE),
   .O_CONV_DONE(O_CONV_DONE), .O_DAC_CODE(O_DAC_CODE),
   .O_CONV_POWER(O_CONV_POWER), .O_HOLD(O_HOLD),
   .O_ANALOG_EN(O_ANALOG_EN), .O_PULLUP_DIS(O_PULLUP_DIS),
   .O_IOC_DIS(O_IOC_DIS));

// ==== acpsc_core_model.sv ====
`timescale 1ns/1ps
module acpsc_core_model
   import acpsc_pkg::*;
#(
   parameter logic [9:0] VIN = 10'h2b7  // analog level on the channel
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_sleep_req,  // bench asks the core to sleep
   input wire logic i_wake,       // wake request from the converter
   input wire logic [9:0] i_dac_code,
   output logic o_sleep,
   output logic o_cmp
);
   // ------------------------------------------------------------
   // core sleep state and comparator
   // ------------------------------------------------------------
   logic req_q;  // edge detect, so one request runs one sleep

   // sleep entered once per request, left on wake or request drop
   always_ff @(posedge i_clk)
   begin
      req_q <= i_sleep_req;
      if (i_rst)
         o_sleep <= 1'b0;
      else if (i_wake)
         o_sleep <= 1'b0;
      else if (i_sleep_req && !req_q)
         o_sleep <= 1'b1;
      else if (!i_sleep_req)
         o_sleep <= 1'b0;
   end

   // comparator high while the input is at or above the trial
   assign o_cmp = (VIN >= i_dac_code);
endmodule // acpsc_core_model

// ==== acpsc_top_bench.sv ====
`timescale 1ns/1ps
module acpsc_top_bench;
   import acpsc_pkg::*;
   // ------------------------------------------------------------
   // stimulus and wiring
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic sleep_req = 1'b0;
   logic [31:0] hrdata;
   logic hready, hresp, wake, done, power, hold, sleep, cmp;
   logic [9:0] dac;
   logic [1:0] chan;
   logic [3:0] ana, pud, ioc;
   int miscompares = 0;
   int check_count = 0;
   int done_seen = 0;  // completions seen, to spot a lost abort

   always #20 clk = ~clk;  // 25 mhz
   always @(posedge clk) if (done === 1'b1) done_seen++;

   acpsc_top acpsc_top_i (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_HSEL(1'b1),
      .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
      .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
      .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
      .I_SLEEP(sleep), .O_WAKE(wake), .O_CONV_DONE(done), .I_CMP(cmp),
      .O_DAC_CODE(dac), .O_CONV_POWER(power), .O_HOLD(hold),
      .O_CHANNEL(chan), .O_ANALOG_EN(ana), .O_PULLUP_DIS(pud),
      .O_IOC_DIS(ioc));
   acpsc_core_model acpsc_core_model_i (.i_clk(clk), .i_rst(rst),
      .i_sleep_req(sleep_req), .i_wake(wake), .i_dac_code(dac),
      .o_sleep(sleep), .o_cmp(cmp));

   // ------------------------------------------------------------
   // bus and checking tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one single ahb transfer; never assumes a wait count
   task automatic bus(input logic wr, input logic [7:0] idx,
                      input logic [7:0] wd, output logic [7:0] rd);
      haddr <= {22'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata[7:0];
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] r;
      bus(1'b1, idx, d, r);
   endtask

   task automatic rchk(input logic [7:0] idx, input logic [7:0] exp,
                       input string what);
      logic [7:0] r;
      bus(1'b0, idx, 8'h00, r);
      check(what, {24'h0, r}, {24'h0, exp});
   endtask

   // start a conversion, time the start delay and the busy span
   task automatic conv(input logic [7:0] c, output int d, output int l);
      wr(IDX_CTRL, c);
      d = 0;
      l = 0;
      while (hold !== 1'b1 && d < 300)
      begin
         @(posedge clk);
         d++;
      end
      while (hold === 1'b1 && l < 2000)
      begin
         @(posedge clk);
         l++;
      end
   endtask

   // conversion clock period in system clocks per select code
   function automatic int tad(input logic [2:0] cs);
      case (cs)
         3'h0: return 2;
         3'h1: return 8;
         3'h2: return 32;
         3'h4: return 4;
         3'h5: return 16;
         3'h6: return 64;
         default: return RC_DIV_CLKS;
      endcase
   endfunction

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial
   begin
      int d0, l0, d, l, n;
      logic [2:0] codes [8];
      codes = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3, 3'h7};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rchk(IDX_ANALOG_SEL, 8'h0f, "select reset");
      rchk(IDX_CTRL, 8'h00, "ctrl reset");
      check("pins reset", ana, 4'hf);
      wr(8'h40, 8'hff);
      rchk(8'h40, 8'h00, "unmapped");
      wr(IDX_ANALOG_SEL, 8'hf5);
      rchk(IDX_ANALOG_SEL, 8'h75, "select top bit");
      check("analog en", ana, 4'h5);
      check("pullup dis", pud, 4'h5);
      check("ioc dis", ioc, 4'h5);
      $display("test 1 done");
      // every clock code: span grows by eleven conversion clocks
      foreach (codes[i])
      begin
         wr(IDX_ANALOG_SEL, {1'b0, codes[i], 4'h5});
         wr(IDX_CTRL, 8'h05);
         repeat (500) @(posedge clk);
         conv(8'h07, d, l);
         if (i == 0)
         begin
            d0 = d;
            l0 = l;
         end
         check("busy span", l, l0 + 11 * (tad(codes[i]) - 2));
         check("start delay", d, d0 + ((i > 5) ? INSTR_CLKS : 0));
         rchk(IDX_CTRL, 8'h05, "go cleared");
         rchk(IDX_RESULT_HIGH, 8'had, "left high");
         rchk(IDX_RESULT_LOW, 8'hc0, "left low");
      end
      $display("test 2 done");
      wr(IDX_ANALOG_SEL, 8'h05);
      conv(8'h87, d, l);
      rchk(IDX_RESULT_HIGH, 8'h02, "right high");
      rchk(IDX_RESULT_LOW, 8'hb7, "right low");
      check("channel", chan, 2'h1);
      $display("test 3 done");
      // sleep on a divided clock aborts the conversion
      wr(IDX_ANALOG_SEL, 8'h65);
      n = done_seen;
      conv(8'h07, d, l);
      wr(IDX_CTRL, 8'h07);
      repeat (100) @(posedge clk);
      sleep_req <= 1'b1;
      repeat (5) @(posedge clk);
      check("abort hold", hold, 1'b0);
      check("abort power", power, 1'b0);
      repeat (800) @(posedge clk);
      check("abort no result", done_seen, n + 1);
      sleep_req <= 1'b0;
      repeat (3) @(posedge clk);
      check("power back", power, 1'b1);
      rchk(IDX_CTRL, 8'h05, "on kept");
      rchk(IDX_RESULT_LOW, 8'hc0, "result kept");
      $display("test 4 done");
      // rc clock through sleep, interrupt enabled: wake
      wr(IDX_ANALOG_SEL, 8'h35);
      wr(IDX_CTRL, 8'h47);
      sleep_req <= 1'b1;
      n = 0;
      while (wake !== 1'b1 && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
      check("wake", wake, 1'b1);
      sleep_req <= 1'b0;
      rchk(IDX_CTRL, 8'h45, "go after wake");
      $display("test 5 done");
      // rc clock through sleep, interrupt disabled: power down
      wr(IDX_CTRL, 8'h07);
      sleep_req <= 1'b1;
      n = 0;
      while (done !== 1'b1 && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
      repeat (4) @(posedge clk);
      check("sleep power down", power, 1'b0);
      check("still asleep", sleep, 1'b1);
      rchk(IDX_CTRL, 8'h05, "on stays");
      sleep_req <= 1'b0;
      $display("test 6 done");
      // reset in mid conversion
      // let the core leave sleep so the power gate opens before the start
      repeat (3) @(posedge clk);
      wr(IDX_CTRL, 8'h07);
      repeat (20) @(posedge clk);
      check("running", hold, 1'b1);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check("reset hold", hold, 1'b0);
      rchk(IDX_CTRL, 8'h00, "ctrl cleared");
      rchk(IDX_ANALOG_SEL, 8'h0f, "select cleared");
      rchk(IDX_RESULT_HIGH, 8'had, "high kept");
      $display("test 7 done");
      summarize();
   end

   // hang guard, about three times the roughly ten thousand cycles the tests need
   initial
   begin
      repeat (30000) @(posedge clk);
      miscompares++;
      summarize();
   end
endmodule // acpsc_top_bench
